// ---- flash_cmd_consts.svh ----
// opcodes, field positions, register offsets and timing counts
// How it works
// RULE1: opcode B9h enters power-down after entry delay
// RULE2: entry refused while write operation runs
// RULE3: powered down: only release and resets heard
// RULE4: release opcode ABh; extra clocks void it
// RULE5: release finishes after select high plus delay
// RULE6: resets and power-up leave power-down
// RULE7: 35h enters quad, F5h leaves, immediately
// RULE8: host issues no write enable first
// RULE9: CRC-64 ECMA polynomial, compared with expected
// RULE10: bytes fed LSB first, start from zero
// RULE11: CRC check ignores the write latch
// RULE12: stop below start aborts, flag bit 1
// RULE13: host range at least one byte, one die
// RULE14: mismatch sets flag bit 4
// RULE15: suspend sets flag bit 2, check continues
// RULE16: hardware or software reset aborts check
// RULE17: failed check stores CRC; read with 96h
// RULE18: readback buffer cleared when check starts
// RULE19: readback buffer cleared at power-up, resets
// RULE20: buffer read from location 0, zeros past 64
// RULE21: host sends 27h, FEh, CRC, start, stop
// RULE22: select rise after last byte starts check
// RULE23: busy bit shown while the check runs
`ifndef FLASH_CMD_CONSTS_SVH
`define FLASH_CMD_CONSTS_SVH

`define OP_DP_ENTER 8'hb9
`define OP_DP_RELEASE 8'hab
`define OP_QUAD_ENTER 8'h35
`define OP_QUAD_EXIT 8'hf5
`define OP_RST_ENABLE 8'h66
`define OP_RST 8'h99
`define OP_SUSPEND 8'h75
`define OP_RESUME 8'h7a
`define OP_RDBACK 8'h96
`define OP_CRC_DEFAULT 8'h9b
`define CRC_SUBCMD 8'h27
`define CRC_OPTION 8'hfe
`define CRC_SEQ_BYTES 7'h13
`define CRC_POLY 64'h42f0e1eba9ea3693
`define RDBACK_LOCS 7'h40

`define FLAG_RANGE_BIT 1
`define FLAG_SUSP_BIT 2
`define FLAG_FAIL_BIT 4

`define REG_STATUS 12'h000
`define REG_FLAG 12'h004
`define REG_CTRL 12'h008
`define CTRL_WIP_BIT 0
`define CTRL_RST_BIT 1

`define CLK_MHZ 50
`define DP_ENTRY_NS 3000
`define DP_RELEASE_NS 30000
`define RST_RECOVERY_NS 40000
`define DP_ENTRY_CYC 12'((`DP_ENTRY_NS * `CLK_MHZ + 999) / 1000)
`define DP_RELEASE_CYC 12'((`DP_RELEASE_NS * `CLK_MHZ + 999) / 1000)
`define RST_RECOVERY_CYC 12'((`RST_RECOVERY_NS * `CLK_MHZ + 999) / 1000)

`endif

// ---- flash_cmd_core.sv ----
// serial flash command core: power-down, quad protocol, CRC range check
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`include "flash_cmd_consts.svh"
module flash_cmd_core import flash_cmd_pkg::*; #(
    parameter logic [7:0] CRC_OPCODE = `OP_CRC_DEFAULT
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic hw_rst_n_in,
    input wire logic sel_n_in,
    input wire logic sclk_in,
    input wire logic [3:0] io_lines_in,
    output logic [3:0] io_lines_out,
    output logic [3:0] io_lines_oe_n_out,
    output logic mem_rd_out,
    output logic [31:0] mem_addr_out,
    input wire logic [7:0] mem_data_in,
    input wire logic mem_ack_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic powered_down_out,
    output logic quad_mode_out
);

    function automatic logic [63:0] crc_byte(input logic [63:0] c,
                                             input logic [7:0] d);
        logic [63:0] r;
        logic fb;
        r = c;
        for (int i = 0; i < 8; i++) begin
            fb = r[63] ^ d[i];
            r = {r[62:0], 1'b0} ^ (fb ? `CRC_POLY : 64'h0);
        end
        return r;
    endfunction : crc_byte

    // pins are asynchronous: two flops before any use
    logic [6:0] sync1_r;
    logic [6:0] sync2_r;
    logic sclk_q_r;
    logic sel_q_r;
    logic hwr_q_r;
    wire logic sel_n_s = sync2_r[0];
    wire logic sclk_s = sync2_r[1];
    wire logic hwr_s = sync2_r[2];
    wire logic [3:0] io_s = sync2_r[6:3];

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sync1_r <= 7'h05;
            sync2_r <= 7'h05;
            sclk_q_r <= 1'b0;
            sel_q_r <= 1'b1;
            hwr_q_r <= 1'b1;
        end else begin
            sync1_r <= {io_lines_in, hw_rst_n_in, sclk_in, sel_n_in};
            sync2_r <= sync1_r;
            sclk_q_r <= sclk_s;
            sel_q_r <= sel_n_s;
            hwr_q_r <= hwr_s;
        end
    end

    // serial clock must stay well below a quarter of clk_in
    wire logic sclk_rise = sclk_s & ~sclk_q_r & ~sel_n_s;
    wire logic sclk_fall = ~sclk_s & sclk_q_r & ~sel_n_s;
    wire logic frame_end = sel_n_s & ~sel_q_r;
    wire logic hw_rst_fall = ~hwr_s & hwr_q_r;

    logic pd_r;
    logic quad_r;
    logic wip_r;
    logic rst_en_r;
    tact_t tact_r;
    logic [11:0] tcnt_r;
    crc_st_t crc_st_r;
    flag_t flag_r;

    // frame assembly
    logic [7:0] shift_r;
    logic [2:0] bitcnt_r;
    logic [6:0] bytecnt_r;
    logic [7:0] cmd_r;
    logic hdr_ok_r;
    logic [127:0] payload_r;

    wire logic [3:0] step = quad_r ? 4'h4 : 4'h1;
    wire logic [3:0] cnt_sum = {1'b0, bitcnt_r} + step;
    wire logic byte_done = sclk_rise & cnt_sum[3];
    wire logic [7:0] shift_nxt = quad_r ? {shift_r[3:0], io_s}
                                        : {shift_r[6:0], io_s[0]};
    wire logic in_payload = (bytecnt_r >= 7'h03) &&
                            (bytecnt_r < `CRC_SEQ_BYTES);

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            shift_r <= 8'h00;
            bitcnt_r <= 3'h0;
            bytecnt_r <= 7'h00;
            cmd_r <= 8'h00;
            hdr_ok_r <= 1'b0;
            payload_r <= 128'h0;
        end else if (sel_n_s) begin
            bitcnt_r <= 3'h0;
            bytecnt_r <= 7'h00;
        end else if (sclk_rise) begin
            shift_r <= shift_nxt;
            bitcnt_r <= cnt_sum[2:0];
            if (byte_done) begin
                if (bytecnt_r != 7'h7f)
                    bytecnt_r <= bytecnt_r + 7'h01;
                if (bytecnt_r == 7'h00)
                    cmd_r <= shift_nxt;
                if (bytecnt_r == 7'h01)
                    hdr_ok_r <= (shift_nxt == `CRC_SUBCMD);
                if (bytecnt_r == 7'h02)
                    hdr_ok_r <= hdr_ok_r & (shift_nxt == `CRC_OPTION);
                // RULE21 low byte first per field
                if (in_payload)
                    payload_r <= {shift_nxt, payload_r[127:8]};
            end
        end
    end

    // decode at select rise
    wire logic dev_ready = (tact_r == T_NONE);
    // RULE4 any clock beyond the opcode voids it
    wire logic len_ok8 = (bytecnt_r == 7'h01) && (bitcnt_r == 3'h0);
    wire logic len_crc = (bytecnt_r == `CRC_SEQ_BYTES) &&
                         (bitcnt_r == 3'h0);
    wire logic cmd_exec = frame_end & dev_ready & len_ok8;
    wire logic [63:0] exp_crc = payload_r[63:0];
    wire logic [31:0] start_addr = payload_r[95:64];
    wire logic [31:0] stop_addr = payload_r[127:96];
    wire logic crc_busy = (crc_st_r != C_IDLE);

    // RULE1 entry opcode, RULE2 refused while writing, RULE3 gated
    wire logic do_enter = cmd_exec & (cmd_r == `OP_DP_ENTER) & ~pd_r &
                          ~wip_r;
    // RULE4 release opcode
    wire logic do_release = cmd_exec & (cmd_r == `OP_DP_RELEASE) & pd_r;
    // RULE7 quad enter and exit, RULE3 ignored when down
    wire logic do_quad_on = cmd_exec & (cmd_r == `OP_QUAD_ENTER) & ~pd_r;
    wire logic do_quad_off = cmd_exec & (cmd_r == `OP_QUAD_EXIT) & ~pd_r;
    wire logic do_rst_en = cmd_exec & (cmd_r == `OP_RST_ENABLE);
    wire logic do_rst_cmd = cmd_exec & (cmd_r == `OP_RST) & rst_en_r;
    wire logic do_suspend = cmd_exec & (cmd_r == `OP_SUSPEND) & ~pd_r &
                            crc_busy;
    wire logic do_resume = cmd_exec & (cmd_r == `OP_RESUME) & ~pd_r;
    // RULE22 check starts at select rise, RULE11 latch not consulted
    wire logic do_crc = frame_end & dev_ready & ~pd_r & ~crc_busy &
                        (cmd_r == CRC_OPCODE) & hdr_ok_r & len_crc;
    // RULE12 reversed range
    wire logic range_bad = stop_addr < start_addr;

    // APB slave, zero wait states
    wire logic apb_setup = psel_in & ~penable_in;
    wire logic apb_acc = psel_in & penable_in;
    wire logic sel_status = (paddr_in == `REG_STATUS);
    wire logic sel_flag = (paddr_in == `REG_FLAG);
    wire logic sel_ctrl = (paddr_in == `REG_CTRL);
    wire logic mapped = sel_status | sel_flag | sel_ctrl;
    wire logic apb_wr = apb_acc & pwrite_in & mapped;
    wire logic ctrl_rst_wr = apb_wr & sel_ctrl & pwdata_in[`CTRL_RST_BIT];
    // RULE16 every reset source aborts the check
    wire logic reset_evt = do_rst_cmd | hw_rst_fall | ctrl_rst_wr;

    wire logic [31:0] status_word = {27'h0, ~dev_ready, wip_r, crc_busy,
                                     quad_r, pd_r};
    wire logic [31:0] flag_word = {27'h0, flag_r.crc_fail, 1'b0,
                                   flag_r.suspended, flag_r.range_err,
                                   1'b0};
    wire logic [31:0] rd_mux = sel_status ? status_word :
                               sel_flag ? flag_word :
                               sel_ctrl ? {31'h0, wip_r} : 32'h0;
    logic [31:0] prdata_r;
    assign prdata_out = prdata_r;
    assign pready_out = apb_acc;
    assign pslverr_out = apb_acc & ~mapped;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            prdata_r <= 32'h0;
            wip_r <= 1'b0;
        end else begin
            if (apb_setup)
                prdata_r <= rd_mux;
            if (apb_wr & sel_ctrl)
                wip_r <= pwdata_in[`CTRL_WIP_BIT];
        end
    end

    // mode, reset latch and delay timer
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            // RULE6 power-up comes up in standby
            pd_r <= 1'b0;
            quad_r <= 1'b0;
            rst_en_r <= 1'b0;
            tact_r <= T_NONE;
            tcnt_r <= 12'h000;
        end else if (reset_evt) begin
            // RULE6 reset leaves power-down at once, recovery delay follows
            pd_r <= 1'b0;
            quad_r <= 1'b0;
            rst_en_r <= 1'b0;
            tact_r <= T_RECOVER;
            tcnt_r <= `RST_RECOVERY_CYC;
        end else begin
            if (frame_end & dev_ready)
                rst_en_r <= do_rst_en;
            if (do_quad_on)
                quad_r <= 1'b1;
            else if (do_quad_off)
                quad_r <= 1'b0;
            if (do_enter) begin
                tact_r <= T_ENTER;
                tcnt_r <= `DP_ENTRY_CYC;
            end else if (do_release) begin
                // RULE5 standby only after the release delay
                tact_r <= T_RELEASE;
                tcnt_r <= `DP_RELEASE_CYC;
            end else if (tact_r != T_NONE) begin
                tcnt_r <= tcnt_r - 12'h001;
                if (tcnt_r == 12'h001) begin
                    tact_r <= T_NONE;
                    // RULE1 down once the entry delay ends
                    if (tact_r == T_ENTER)
                        pd_r <= 1'b1;
                    if (tact_r == T_RELEASE)
                        pd_r <= 1'b0;
                end
            end
        end
    end

    // CRC engine
    logic [63:0] crc_r;
    logic [63:0] exp_r;
    logic [31:0] addr_r;
    logic [31:0] stop_r;
    wire logic fetch_ack = (crc_st_r == C_FETCH) & mem_ack_in;
    wire logic cmp_now = (crc_st_r == C_CMP);
    wire logic mismatch = cmp_now & (crc_r != exp_r);
    assign mem_rd_out = (crc_st_r == C_FETCH);
    assign mem_addr_out = addr_r;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            crc_st_r <= C_IDLE;
            crc_r <= 64'h0;
            exp_r <= 64'h0;
            addr_r <= 32'h0;
            stop_r <= 32'h0;
        end else if (reset_evt) begin
            // RULE16 abort in progress
            crc_st_r <= C_IDLE;
        end else begin
            unique case (crc_st_r)
                C_IDLE: begin
                    if (do_crc & ~range_bad) begin
                        // RULE10 all-zero starting value
                        crc_r <= 64'h0;
                        exp_r <= exp_crc;
                        addr_r <= start_addr;
                        stop_r <= stop_addr;
                        crc_st_r <= C_FETCH;
                    end
                end
                C_FETCH: begin
                    if (mem_ack_in) begin
                        // RULE9 RULE10 one byte, LSB first
                        crc_r <= crc_byte(crc_r, mem_data_in);
                        if (addr_r == stop_r)
                            crc_st_r <= C_CMP;
                        else
                            addr_r <= addr_r + 32'h1;
                    end
                end
                // RULE23 busy drops as the result is posted
                C_CMP: crc_st_r <= C_IDLE;
                default: crc_st_r <= C_IDLE;
            endcase
        end
    end

    // flags: a hardware set wins over any clear in the same cycle
    wire logic flag_wr = apb_wr & sel_flag;
    flag_t flag_set;
    flag_t flag_clr;
    assign flag_set.range_err = do_crc & range_bad;
    assign flag_set.suspended = do_suspend;
    assign flag_set.crc_fail = mismatch;
    assign flag_clr.range_err = flag_wr & pwdata_in[`FLAG_RANGE_BIT];
    // RULE15 resume clears the suspend flag
    assign flag_clr.suspended = (flag_wr & pwdata_in[`FLAG_SUSP_BIT]) |
                                do_resume;
    assign flag_clr.crc_fail = flag_wr & pwdata_in[`FLAG_FAIL_BIT];

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in)
            flag_r <= '0;
        else
            // RULE12 RULE14 RULE15 sticky flag bits
            flag_r <= flag_set | (flag_r & ~flag_clr);
    end

    // readback buffer; only the first eight locations ever hold data
    logic [7:0] rdbuf_r [0:63];
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            // RULE19 zeros at power-up
            for (int i = 0; i < 64; i++)
                rdbuf_r[i] <= 8'h00;
        end else if (reset_evt | do_crc) begin
            // RULE18 RULE19 cleared at start and on resets
            for (int i = 0; i < 64; i++)
                rdbuf_r[i] <= 8'h00;
        end else if (mismatch) begin
            // RULE17 keep computed value only on failure
            for (int i = 0; i < 8; i++)
                rdbuf_r[i] <= crc_r[8*i +: 8];
        end
    end

    // readback output, shifted on the falling serial edge
    wire logic rd_active = (cmd_r == `OP_RDBACK) & ~pd_r & dev_ready &
                           (bytecnt_r != 7'h00);
    wire logic [6:0] rd_idx = bytecnt_r - 7'h01;
    // RULE20 start at location 0, zeros past the end
    wire logic [7:0] rd_byte = (rd_idx < `RDBACK_LOCS) ?
                               rdbuf_r[rd_idx[5:0]] : 8'h00;
    wire logic [3:0] rd_nib = (bitcnt_r == 3'h0) ? rd_byte[7:4]
                                                  : rd_byte[3:0];
    wire logic rd_bit = rd_byte[3'h7 - bitcnt_r];
    logic [3:0] io_out_r;
    logic [3:0] io_oe_n_r;
    assign io_lines_out = io_out_r;
    assign io_lines_oe_n_out = io_oe_n_r;
    assign powered_down_out = pd_r;
    assign quad_mode_out = quad_r;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            io_out_r <= 4'h0;
            io_oe_n_r <= 4'hf;
        end else if (sel_n_s) begin
            io_out_r <= 4'h0;
            io_oe_n_r <= 4'hf;
        end else if (sclk_fall & rd_active) begin
            io_out_r <= quad_r ? rd_nib : {2'b00, rd_bit, 1'b0};
            io_oe_n_r <= quad_r ? 4'h0 : 4'hd;
        end
    end

    AST_DP_REJECT: assert property ( // RULE2
        @(posedge clk_in) disable iff (sys_rst_in)
        (cmd_exec && cmd_r == `OP_DP_ENTER && wip_r && !reset_evt)
        |=> (tact_r != T_ENTER) && $stable(pd_r))
        else $error("power-down entry taken during write");

    AST_DP_ENTER: assert property ( // RULE1
        @(posedge clk_in) disable iff (sys_rst_in)
        (tact_r == T_ENTER && tcnt_r == 12'h001 && !reset_evt)
        |=> pd_r && dev_ready)
        else $error("power-down not entered after delay");

    AST_PD_IGNORE: assert property ( // RULE3
        @(posedge clk_in) disable iff (sys_rst_in)
        (pd_r && frame_end && !reset_evt) |=> $stable(quad_r) &&
        $stable(flag_r))
        else $error("command acted on while powered down");

    AST_RELEASE_HOLD: assert property ( // RULE5
        @(posedge clk_in) disable iff (sys_rst_in)
        (do_release && !reset_evt) |=> pd_r [*8])
        else $error("release ended before its delay");

    AST_RANGE_ABORT: assert property ( // RULE12
        @(posedge clk_in) disable iff (sys_rst_in)
        (do_crc && range_bad && !reset_evt) |=> flag_r.range_err &&
        crc_st_r == C_IDLE)
        else $error("reversed range not aborted");

    AST_FAIL_STORE: assert property ( // RULE14
        @(posedge clk_in) disable iff (sys_rst_in)
        (mismatch && !reset_evt) |=> flag_r.crc_fail &&
        rdbuf_r[0] == $past(crc_r[7:0]) && !crc_busy)
        else $error("failed check not reported");

    AST_SUSPEND: assert property ( // RULE15
        @(posedge clk_in) disable iff (sys_rst_in)
        (do_suspend && crc_st_r == C_FETCH && !reset_evt)
        |=> flag_r.suspended && crc_busy)
        else $error("suspend mishandled during check");

    AST_RESET_ABORT: assert property ( // RULE16
        @(posedge clk_in) disable iff (sys_rst_in)
        reset_evt |=> !crc_busy && !pd_r && rdbuf_r[0] == 8'h00)
        else $error("reset did not abort check");

    AST_BUF_CLEAR: assert property ( // RULE18
        @(posedge clk_in) disable iff (sys_rst_in)
        (do_crc && !reset_evt) |=> rdbuf_r[7] == 8'h00 ##1
        rdbuf_r[0] == 8'h00)
        else $error("buffer not cleared at check start");

    AST_RD_ZERO: assert property ( // RULE20
        @(posedge clk_in) disable iff (sys_rst_in)
        (sclk_fall && rd_active && rd_idx >= `RDBACK_LOCS)
        |=> io_out_r == 4'h0)
        else $error("nonzero data past buffer end");

endmodule : flash_cmd_core

// ---- flash_cmd_pkg.sv ----
// types shared by the command core
package flash_cmd_pkg;
    typedef enum logic [1:0] {
        C_IDLE = 2'b00,
        C_FETCH = 2'b01,
        C_CMP = 2'b10
    } crc_st_t;

    typedef enum logic [1:0] {
        T_NONE = 2'b00,
        T_ENTER = 2'b01,
        T_RELEASE = 2'b10,
        T_RECOVER = 2'b11
    } tact_t;

    typedef struct packed {
        logic crc_fail;
        logic suspended;
        logic range_err;
    } flag_t;
endpackage : flash_cmd_pkg

// ---- spi_host_model.sv ----
// serial host model: frames commands and collects read bytes
`timescale 1ns/1ns
module spi_host_model (
    input wire logic clk_in,
    input wire logic [3:0] io_wire_in,
    output logic sel_n_out,
    output logic sclk_out,
    output logic [3:0] io_drv_out
);
    int half = 6;
    logic [7:0] rx;
    logic [7:0] rx_mem [0:79];
    initial begin
        sel_n_out = 1'h1;
        sclk_out = 1'h0;
        io_drv_out = 4'h5;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask : tick
    // select rises half a period after the last bit, or after the last extra clock when extra is nonzero
    // bytes go out as the caller packs them
    task automatic frame(input logic [151:0] v, input int nb,
                         input int extra, input bit quad, input int nrd);
        sel_n_out <= 1'h0;
        for (int i = 0; i < nb + nrd; i++) begin
            for (int k = 0; k < (quad ? 2 : 8); k++) begin
                // released lines toggle so a stale level never passes
                if (i >= nb) io_drv_out <= ~io_drv_out;
                else if (quad) io_drv_out <= v[151-8*i-4*k -: 4];
                else io_drv_out <= {~io_drv_out[3:1], v[151-8*i-k]};
                tick(half);
                sclk_out <= 1'h1;
                rx = quad ? {rx[3:0], io_wire_in} : {rx[6:0], io_wire_in[1]};
                tick(half);
                sclk_out <= 1'h0;
            end
            if (i >= nb) rx_mem[i-nb] = rx;
        end
        repeat (extra) begin
            tick(half);
            sclk_out <= 1'h1;
            tick(half);
            sclk_out <= 1'h0;
        end
        tick(half);
        sel_n_out <= 1'h1;
        io_drv_out <= ~io_drv_out;
        tick(2 * half);
    endtask : frame
endmodule : spi_host_model

// ---- tb_top.sv ----
// self-checking bench for the flash command core
`timescale 1ns/1ns
`include "flash_cmd_consts.svh"
module tb_top;
    logic clk_in, sys_rst_in, hw_rst_n_in, psel_in, penable_in, pwrite_in;
    logic mem_ack_in, mem_rd, pready, pslverr, pd, quad, sel_n, sclk, er;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in, prdata, mem_addr, rd, rnd, a, b;
    logic [7:0] mem_data_in;
    logic [7:0] mem [0:63];
    logic [3:0] io_out, io_oe_n, io_drv, io_wire;
    logic [63:0] c;
    int err_count, n_compared, gap;
    assign io_wire = (io_oe_n & io_drv) | (~io_oe_n & io_out);
    flash_cmd_core flash_cmd_core_inst (.clk_in(clk_in),
        .sys_rst_in(sys_rst_in), .hw_rst_n_in(hw_rst_n_in),
        .sel_n_in(sel_n), .sclk_in(sclk), .io_lines_in(io_wire),
        .io_lines_out(io_out), .io_lines_oe_n_out(io_oe_n),
        .mem_rd_out(mem_rd), .mem_addr_out(mem_addr),
        .mem_data_in(mem_data_in), .mem_ack_in(mem_ack_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr),
        .powered_down_out(pd), .quad_mode_out(quad));
    spi_host_model spi_host_model_inst (.clk_in(clk_in),
        .io_wire_in(io_wire), .sel_n_out(sel_n), .sclk_out(sclk),
        .io_drv_out(io_drv));
    function automatic logic [31:0] xs();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd;
    endfunction : xs
    function automatic logic [63:0] crc_of(input int f, input int t);
        logic [63:0] r;
        r = 64'h0;
        for (int i = f; i <= t; i++) begin
            for (int k = 0; k < 8; k++) begin
                r = {r[62:0], 1'h0} ^
                    ((r[63] ^ mem[i][k]) ? `CRC_POLY : 64'h0);
            end
        end
        return r;
    endfunction : crc_of
    function automatic logic [63:0] sw(input logic [63:0] x);
        for (int i = 0; i < 8; i++) sw[8*i +: 8] = x[56-8*i +: 8];
    endfunction : sw
    task automatic print_verdict();
        $display("compared %0d errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    task automatic tmo();
        err_count++;
        $display("Error wait expected done seen timeout");
        print_verdict();
    endtask : tmo
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] ad,
                       input logic [31:0] d);
        int k;
        psel_in <= 1'h1;
        pwrite_in <= w;
        paddr_in <= ad;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'h1;
        k = 0;
        do begin
            @(posedge clk_in);
            k++;
        end while (pready !== 1'h1 && k < 20);
        rd = prdata;
        er = pslverr;
        psel_in <= 1'h0;
        penable_in <= 1'h0;
        @(posedge clk_in);
        if (k >= 20) tmo();
    endtask : apb
    task automatic poll(input int bi, input logic v);
        int k;
        k = 0;
        do begin
            apb(1'h0, `REG_STATUS, 32'h0);
            k++;
        end while (rd[bi] !== v && k < 3000);
        if (k >= 3000) tmo();
    endtask : poll
    task automatic cmd(input logic [7:0] op, input int extra, input bit q);
        spi_host_model_inst.frame({op, 144'h0}, 1, extra, q, 0);
    endtask : cmd
    task automatic crc_cmd(input logic [63:0] e, input logic [31:0] f, t);
        spi_host_model_inst.frame({`OP_CRC_DEFAULT, `CRC_SUBCMD, `CRC_OPTION,
            sw(e), sw({t, f})}, 19, 0, 0, 0);
    endtask : crc_cmd
    task automatic flag(input logic [31:0] e);
        apb(1'h0, `REG_FLAG, 32'h0);
        chk("flag", e, rd);
    endtask : flag
    task automatic rb(input int n, input logic [63:0] e);
        spi_host_model_inst.frame({`OP_RDBACK, 144'h0}, 1, 0, quad, n);
        for (int j = 0; j < n; j++) begin
            chk("readback", j < 8 ? e[8*j +: 8] : 8'h0,
                spi_host_model_inst.rx_mem[j]);
        end
    endtask : rb
    // array model acks after a random gap so the check can run slow
    always @(posedge clk_in) begin
        mem_ack_in <= mem_rd && !mem_ack_in && (xs() % gap == 0);
        mem_data_in <= mem[mem_addr[5:0]];
    end
    initial begin
        clk_in = 1'h0;
        forever #10 clk_in = ~clk_in;
    end
    initial begin
        sys_rst_in = 1'h1;
        hw_rst_n_in = 1'h1;
        psel_in = 1'h0;
        penable_in = 1'h0;
        pwrite_in = 1'h0;
        paddr_in = 12'h0;
        pwdata_in = 32'h0;
        err_count = 0;
        n_compared = 0;
        gap = 6;
        rnd = 32'h5f;
        for (int i = 0; i < 64; i++) mem[i] = 8'(xs());
        repeat (4) @(posedge clk_in);
        sys_rst_in <= 1'h0;
        @(posedge clk_in);
        apb(1'h0, `REG_STATUS, 32'h0);
        chk("status", 32'h0, rd);
        apb(1'h0, 12'h00c, 32'h0);
        chk("unmapped", 32'h1, er);
        rb(8, 64'h0);
        spi_host_model_inst.half = 9;
        cmd(`OP_QUAD_ENTER, 0, 0);
        spi_host_model_inst.half = 6;
        chk("quad on", 32'h1, quad);
        cmd(`OP_QUAD_EXIT, 0, 1);
        chk("quad off", 32'h0, quad);
        apb(1'h1, `REG_CTRL, 32'h1);
        cmd(`OP_DP_ENTER, 0, 0);
        repeat (200) @(posedge clk_in);
        chk("pd busy", 32'h0, pd);
        apb(1'h1, `REG_CTRL, 32'h0);
        cmd(`OP_DP_ENTER, 0, 0);
        chk("pd early", 32'h0, pd);
        repeat (150) @(posedge clk_in);
        chk("pd on", 32'h1, pd);
        cmd(`OP_QUAD_ENTER, 0, 0);
        chk("pd quad", 32'h0, quad);
        flag(32'h0);
        cmd(`OP_DP_RELEASE, 1, 0);
        repeat (1600) @(posedge clk_in);
        chk("void release", 32'h1, pd);
        cmd(`OP_DP_RELEASE, 0, 0);
        repeat (1400) @(posedge clk_in);
        chk("release wait", 32'h1, pd);
        repeat (200) @(posedge clk_in);
        chk("release", 32'h0, pd);
        cmd(`OP_DP_ENTER, 0, 0);
        repeat (150) @(posedge clk_in);
        cmd(`OP_RST_ENABLE, 0, 0);
        cmd(`OP_RST, 0, 0);
        chk("reset pd", 32'h0, pd);
        poll(4, 1'h0);
        a = xs() % 32;
        b = a + 16 + xs() % 16;
        c = crc_of(a, b);
        crc_cmd(~c, a, b);
        apb(1'h0, `REG_STATUS, 32'h0);
        chk("busy", 32'h1, rd[2]);
        poll(2, 1'h0);
        flag(32'h10);
        rb(66, c);
        apb(1'h1, `REG_FLAG, 32'h16);
        crc_cmd(crc_of(a, a), a, a);
        poll(2, 1'h0);
        flag(32'h0);
        rb(8, 64'h0);
        crc_cmd(64'h0, b, a);
        flag(32'h2);
        apb(1'h1, `REG_FLAG, 32'h2);
        gap = 40;
        crc_cmd(~crc_of(0, 63), 0, 63);
        cmd(`OP_SUSPEND, 0, 0);
        flag(32'h4);
        poll(2, 1'h0);
        flag(32'h14);
        cmd(`OP_RESUME, 0, 0);
        flag(32'h10);
        apb(1'h1, `REG_FLAG, 32'h10);
        rb(8, crc_of(0, 63));
        cmd(`OP_QUAD_ENTER, 0, 0);
        rb(8, crc_of(0, 63));
        apb(1'h1, `REG_CTRL, 32'h2);
        poll(4, 1'h0);
        chk("reset quad", 32'h0, quad);
        rb(8, 64'h0);
        crc_cmd(64'h0, 0, 63);
        hw_rst_n_in <= 1'h0;
        repeat (4) @(posedge clk_in);
        hw_rst_n_in <= 1'h1;
        repeat (4) @(posedge clk_in);
        apb(1'h0, `REG_STATUS, 32'h0);
        chk("abort", 32'h0, rd[2]);
        poll(4, 1'h0);
        flag(32'h0);
        rb(8, 64'h0);
        print_verdict();
    end
endmodule : tb_top
